// File: shared/cpuod_pkg.sv
// constants and types shared by the opcode decoder files
package cpuod_pkg;
  // addressing modes, one-hot
  typedef enum logic [13:0] {
    implied_mode                = 14'h0001,
    literal_operand_mode        = 14'h0002,
    direct_mode                 = 14'h0004,
    full_address_mode           = 14'h0008,
    relative_mode               = 14'h0010,
    pointer_mode                = 14'h0020,
    pointer_byte_offset_mode    = 14'h0040,
    pointer_word_offset_mode    = 14'h0080,
    pointer_postinc_mode        = 14'h0100,
    pointer_offset_postinc_mode = 14'h0200,
    stack_byte_offset_mode      = 14'h0400,
    stack_word_offset_mode      = 14'h0800,
    dir_to_dir_mode             = 14'h1000,
    literal_to_dir_mode         = 14'h2000
  } cpuod_mode_e;
  // bus cycle kinds, one-hot
  typedef enum logic [6:0] {
    cyc_free  = 7'h01,
    cyc_fetch = 7'h02,
    cyc_read  = 7'h04,
    cyc_write = 7'h08,
    cyc_push  = 7'h10,
    cyc_pop   = 7'h20,
    cyc_vect  = 7'h40
  } cpuod_cyc_e;
  // instruction classes
  typedef enum logic [7:0] {
    cls_bit_branch  = 8'h01,
    cls_bit_write   = 8'h02,
    cls_rel_branch  = 8'h04,
    cls_rmw         = 8'h08,
    cls_control     = 8'h10,
    cls_regmem      = 8'h20,
    cls_pointer     = 8'h40,
    cls_illegal     = 8'h80
  } cpuod_cls_e;
  // decoder sequence states
  typedef enum logic [2:0] {
    st_page1 = 3'h1,
    st_page2 = 3'h2,
    st_hold  = 3'h4
  } cpuod_state_e;
  localparam logic [7:0] OP_PREBYTE = 8'h9e;
  localparam logic [7:0] OP_PTR_LD_IMM = 8'h45;
  localparam logic [7:0] OP_PTR_LD_DIR = 8'h55;
  localparam logic [7:0] OP_PTR_CP_IMM = 8'h65;
  localparam logic [7:0] OP_PTR_CP_DIR = 8'h75;
  localparam logic [7:0] OP_PTR_ST_EXT = 8'h96;
  localparam logic [7:0] OP_STORE_A_NOOFF = 8'hf7;
  localparam logic [7:0] OP_STORE_X_NOOFF = 8'hff;
  localparam logic [15:0] VECTOR_PAGE = 16'hff00;
  // flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0] FLAG_RESET = 8'h68;
  localparam logic [7:0] FLAG_FIXED_ONES = 8'h60;
endpackage

// File: core/cpuod_table.sv
// registered opcode attribute lookup for page-one control-column opcodes 80-9F
`timescale 1ns/100ps
`default_nettype none
module cpuod_table
  import cpuod_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic [7:0] op,
  output logic [2:0] len,
  output logic [3:0] cycles,
  output logic legal
);
  logic [2:0] l;
  logic [3:0] c;
  logic ok;
  // control column lengths and cycles; zero cycles marks a hole
  always_comb
  begin
    l = 3'h1;
    c = 4'h0;
    ok = 1'b1;
    case (op)
      8'h80: c = 4'h9; 8'h81: c = 4'h6; 8'h82: c = 4'h5; 8'h83: c = 4'hb;
      8'h84: c = 4'h1; 8'h85: c = 4'h1; 8'h86: c = 4'h3; 8'h87: c = 4'h2;
      8'h88: c = 4'h3; 8'h89: c = 4'h2; 8'h8a: c = 4'h3; 8'h8b: c = 4'h2;
      8'h8c: c = 4'h1; 8'h8e: c = 4'h2; 8'h8f: c = 4'h2;
      8'h94: c = 4'h2; 8'h95: c = 4'h2; 8'h97: c = 4'h1;
      8'h98: c = 4'h1; 8'h99: c = 4'h1; 8'h9a: c = 4'h1; 8'h9b: c = 4'h1;
      8'h9c: c = 4'h1; 8'h9d: c = 4'h1; 8'h9f: c = 4'h1;
      8'h90, 8'h91, 8'h92, 8'h93:
      begin
        l = 3'h2;
        c = 4'h3;
      end
      8'h96:
      begin
        l = 3'h3;
        c = 4'h5;
      end
      default: ok = 1'b0;
    endcase
  end
  // registered so the reply lands one enabled edge after the opcode
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      len <= l;
      cycles <= c;
      legal <= ok;
    end
  end
endmodule
`default_nettype wire

// File: core/cpuod_decoder.sv
// first-page opcode decoder with prebyte tracking and bus-cycle plan
//
// How it works
// RULE1 - free cycle is one clock, no bus use, signalled as a read
// RULE2 - fetch cycle reads next sequential program location
// RULE3 - operand read moves one byte from memory into core
// RULE4 - operand write moves one byte from core to memory
// RULE5 - push cycle writes a single byte to stack
// RULE6 - pop cycle reads a single byte from stack
// RULE7 - vector reads from top page, high byte before low byte
// RULE8 - flag register holds V, H, I, N, Z and carry flags
// RULE9 - pointer post-increment forms with and without byte offset decoded
// RULE10 - stack-relative modes with byte or word offset decoded
// RULE11 - pointer indexed with no, byte or word offset decoded
// RULE12 - 00-0F bit test-and-branch, three bytes, five cycles
// RULE13 - 10-1F bit set or clear on direct page, two bytes, five cycles
// RULE14 - 20-2F relative branches, two bytes, three cycles
// RULE15 - read-modify-write mode from high nibble, with special codes
// RULE16 - pointer load 45 immediate and 55 direct
// RULE17 - pointer compare 65 immediate and 75 direct
// RULE18 - pointer store 96 extended, three bytes, five cycles
// RULE19 - register/memory mode from high nibble, operation from low nibble
// RULE20 - register/memory cycle counts per mode, F7 and FF take two
// RULE21 - 9E selects second page for following byte
// RULE22 - unmapped opcodes flagged illegal, never executed
`timescale 1ns/100ps
`default_nettype none
module cpuod_decoder
  import cpuod_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic op_valid,
  input wire logic [7:0] op,
  input wire logic [2:0] kind_req,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic [ADDR_W-1:0] sp,
  input wire logic [7:0] vec_low,
  input wire logic flag_we,
  input wire logic [7:0] flag_in,
  output logic dec_valid,
  output logic [7:0] dec_op,
  output logic page2,
  output logic [7:0] dec_class,
  output logic [13:0] dec_mode,
  output logic [3:0] dec_alu_op,
  output logic [2:0] dec_bit,
  output logic dec_bit_val,
  output logic [2:0] dec_len,
  output logic [3:0] dec_cycles,
  output logic illegal,
  output logic [6:0] cyc_kind,
  output logic bus_req,
  output logic bus_rw,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [7:0] flag_register
);
  cpuod_state_e state;
  logic [7:0] op_q;
  logic was_page2;
  logic vec_phase;
  logic [2:0] tbl_len;
  logic [3:0] tbl_cyc;
  logic tbl_ok;
  cpuod_cls_e next_class;
  logic [13:0] next_mode;
  logic [2:0] next_len;
  logic [3:0] next_cycles;
  logic next_legal;
  logic [3:0] hi;
  logic [3:0] lo;

  // control column lookup lives in its own registered table
  cpuod_table u_table
  (
    .clk(clk),
    .ce(ce),
    .op(op),
    .len(tbl_len),
    .cycles(tbl_cyc),
    .legal(tbl_ok)
  );

  assign hi = op_q[7:4];
  assign lo = op_q[3:0];

  // prebyte tracking: 9e arms page two for the next byte only
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= st_page1;
      op_q <= 8'h00;
      was_page2 <= 1'b0;
    end
    else if (ce)
    begin
      if (op_valid)
      begin
        op_q <= op;
        was_page2 <= (state == st_page2);
        case (state)
          st_page1: state <= (op == OP_PREBYTE) ? st_page2 : st_hold; // [RULE21]
          st_page2: state <= st_hold;
          st_hold: state <= (op == OP_PREBYTE) ? st_page2 : st_hold; // [RULE21]
          default: state <= st_page1;
        endcase
      end
      else if (state == st_hold)
      begin
        state <= st_page1;
      end
    end
  end

  // one delayed valid, aligned with the table register
  logic op_seen;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      op_seen <= 1'b0;
    else if (ce)
      op_seen <= op_valid;
  end

  // class, mode, length and cycle count from the held opcode
  always_comb
  begin
    next_class = cls_illegal;
    next_mode = implied_mode;
    next_len = 3'h1;
    next_cycles = 4'h0;
    next_legal = 1'b1;
    case (hi)
      4'h0:
      begin
        next_class = cls_bit_branch; // [RULE12]
        next_mode = direct_mode;
        next_len = 3'h3;
        next_cycles = 4'h5;
      end
      4'h1:
      begin
        next_class = cls_bit_write; // [RULE13]
        next_mode = direct_mode;
        next_len = 3'h2;
        next_cycles = 4'h5;
      end
      4'h2:
      begin
        next_class = cls_rel_branch; // [RULE14]
        next_mode = relative_mode;
        next_len = 3'h2;
        next_cycles = 4'h3;
      end
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
      begin
        next_class = cls_rmw; // [RULE15]
        case (hi)
          4'h3:
          begin
            next_mode = direct_mode;
            next_len = 3'h2;
            next_cycles = 4'h5;
          end
          4'h4, 4'h5:
          begin
            next_mode = implied_mode;
            next_len = 3'h1;
            next_cycles = 4'h1;
          end
          4'h6:
          begin
            next_mode = pointer_byte_offset_mode; // [RULE11]
            next_len = 3'h2;
            next_cycles = 4'h5;
          end
          default:
          begin
            next_mode = pointer_mode; // [RULE11]
            next_len = 3'h1;
            next_cycles = 4'h4;
          end
        endcase
        // special low-nibble codes override the column defaults [RULE15]
        case (op_q)
          8'h31: {next_mode, next_len, next_cycles} = {direct_mode, 3'h3, 4'h5};
          8'h41: {next_mode, next_len, next_cycles} =
            {literal_operand_mode, 3'h3, 4'h4};
          8'h51: {next_mode, next_len, next_cycles} =
            {literal_operand_mode, 3'h3, 4'h4};
          8'h61: {next_mode, next_len, next_cycles} = // [RULE9]
            {pointer_offset_postinc_mode, 3'h3, 4'h5};
          8'h71: {next_mode, next_len, next_cycles} = // [RULE9]
            {pointer_postinc_mode, 3'h2, 4'h5};
          8'h32: {next_mode, next_len, next_cycles} =
            {full_address_mode, 3'h3, 4'h5};
          8'h42: {next_mode, next_len, next_cycles} = {implied_mode, 3'h1, 4'h5};
          8'h52: {next_mode, next_len, next_cycles} = {implied_mode, 3'h1, 4'h6};
          8'h62, 8'h72: {next_mode, next_len, next_cycles} =
            {implied_mode, 3'h1, 4'h1};
          8'h35: {next_mode, next_len, next_cycles} = {direct_mode, 3'h2, 4'h4};
          8'h3b, 8'h6b: {next_len, next_cycles} = {3'h3, 4'h7};
          8'h4b, 8'h5b: {next_len, next_cycles} = {3'h2, 4'h4};
          8'h7b: {next_len, next_cycles} = {3'h2, 4'h6};
          8'h3d, 8'h6d: next_cycles = 4'h4;
          8'h7d: next_cycles = 4'h3;
          8'h3e: {next_mode, next_len, next_cycles} =
            {full_address_mode, 3'h3, 4'h6};
          8'h4e: {next_mode, next_len, next_cycles} =
            {dir_to_dir_mode, 3'h3, 4'h5};
          8'h5e: {next_mode, next_len, next_cycles} =
            {pointer_postinc_mode, 3'h2, 4'h5};
          8'h6e: {next_mode, next_len, next_cycles} =
            {literal_to_dir_mode, 3'h3, 4'h4};
          8'h7e: {next_mode, next_len, next_cycles} =
            {pointer_postinc_mode, 3'h2, 4'h5};
          default: ;
        endcase
        // pointer pair load and compare sit in these columns
        case (op_q)
          OP_PTR_LD_IMM, OP_PTR_CP_IMM:
          begin
            next_class = cls_pointer; // [RULE16] [RULE17]
            next_mode = literal_operand_mode;
            next_len = 3'h3;
            next_cycles = 4'h3;
          end
          OP_PTR_LD_DIR:
          begin
            next_class = cls_pointer; // [RULE16]
            next_mode = direct_mode;
            next_len = 3'h2;
            next_cycles = 4'h4;
          end
          OP_PTR_CP_DIR:
          begin
            next_class = cls_pointer; // [RULE17]
            next_mode = direct_mode;
            next_len = 3'h2;
            next_cycles = 4'h5;
          end
          default: ;
        endcase
      end
      4'h8, 4'h9:
      begin
        next_class = (op_q == OP_PTR_ST_EXT) ? cls_pointer : cls_control;
        next_mode = (op_q == OP_PTR_ST_EXT) ? full_address_mode // [RULE18]
          : (hi == 4'h9 && !lo[3]) ? relative_mode : implied_mode;
        next_len = tbl_len;
        next_cycles = tbl_cyc;
        next_legal = tbl_ok; // [RULE22]
      end
      default:
      begin
        next_class = cls_regmem; // [RULE19]
        case (hi)
          4'ha: {next_mode, next_len, next_cycles} =
            {literal_operand_mode, 3'h2, 4'h2}; // [RULE20]
          4'hb: {next_mode, next_len, next_cycles} =
            {direct_mode, 3'h2, 4'h3};
          4'hc: {next_mode, next_len, next_cycles} =
            {full_address_mode, 3'h3, 4'h4};
          4'hd: {next_mode, next_len, next_cycles} =
            {pointer_word_offset_mode, 3'h3, 4'h4};
          4'he: {next_mode, next_len, next_cycles} =
            {pointer_byte_offset_mode, 3'h2, 4'h3};
          default: {next_mode, next_len, next_cycles} =
            {pointer_mode, 3'h1, 4'h3};
        endcase
        if (op_q == OP_STORE_A_NOOFF || op_q == OP_STORE_X_NOOFF)
          next_cycles = 4'h2; // [RULE20]
        if (op_q == 8'had)
          next_mode = relative_mode;
        // hole in the literal column: only ac is flagged illegal
        if (op_q == 8'hac)
          next_legal = 1'b0; // [RULE22]
      end
    endcase
    // second page stack forms share the column position [RULE10]
    if (was_page2 && (hi == 4'hd))
      next_mode = stack_word_offset_mode; // [RULE10]
    else if (was_page2 && (hi == 4'he || hi == 4'h6))
      next_mode = stack_byte_offset_mode; // [RULE10]
    if (!next_legal)
      next_class = cls_illegal;
  end

  // registered decode results
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dec_valid <= 1'b0;
      dec_op <= 8'h00;
      page2 <= 1'b0;
      dec_class <= cls_illegal;
      dec_mode <= implied_mode;
      dec_alu_op <= 4'h0;
      dec_bit <= 3'h0;
      dec_bit_val <= 1'b0;
      dec_len <= 3'h0;
      dec_cycles <= 4'h0;
      illegal <= 1'b0;
    end
    else if (ce)
    begin
      // a lone prebyte is not an instruction by itself
      dec_valid <= op_seen && (op_q != OP_PREBYTE || was_page2) && next_legal;
      dec_op <= op_q;
      page2 <= was_page2;
      dec_class <= next_class;
      dec_mode <= next_mode;
      dec_alu_op <= lo; // [RULE19]
      dec_bit <= op_q[3:1]; // [RULE12] [RULE13]
      dec_bit_val <= ~op_q[0]; // [RULE12] [RULE13]
      dec_len <= next_len;
      dec_cycles <= next_cycles;
      // a lone prebyte is a prefix, never an illegal op by itself
      illegal <= op_seen && (op_q != OP_PREBYTE || was_page2) &&
        !next_legal; // [RULE22]
    end
  end

  // bus cycle plan for the requested kind
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cyc_kind <= cyc_free;
      bus_req <= 1'b0;
      bus_rw <= 1'b1;
      bus_addr <= '0;
      vec_phase <= 1'b0;
    end
    else if (ce)
    begin
      bus_rw <= 1'b1;
      bus_req <= 1'b1;
      case (kind_req)
        3'h1:
        begin
          cyc_kind <= cyc_fetch;
          bus_addr <= pc; // [RULE2]
        end
        3'h2:
        begin
          cyc_kind <= cyc_read; // [RULE3]
        end
        3'h3:
        begin
          cyc_kind <= cyc_write;
          bus_rw <= 1'b0; // [RULE4]
        end
        3'h4:
        begin
          cyc_kind <= cyc_push;
          bus_rw <= 1'b0; // [RULE5]
          bus_addr <= sp;
        end
        3'h5:
        begin
          cyc_kind <= cyc_pop; // [RULE6]
          bus_addr <= sp;
        end
        3'h6:
        begin
          cyc_kind <= cyc_vect;
          // high byte at the even address first, then low [RULE7]
          bus_addr <= ADDR_W'(VECTOR_PAGE) |
            ADDR_W'({vec_low[7:1], vec_phase});
          vec_phase <= ~vec_phase;
        end
        default:
        begin
          cyc_kind <= cyc_free;
          bus_req <= 1'b0; // [RULE1]
          vec_phase <= 1'b0;
        end
      endcase
    end
  end

  // condition flags; the two unused bits always read as one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      flag_register <= FLAG_RESET;
    else if (ce && flag_we)
      flag_register <= flag_in | FLAG_FIXED_ONES; // [RULE8]
  end
endmodule
`default_nettype wire

// File: testbench/cpuod_decoder_sva.sv
// port-level assertion checker for the opcode decoder
`timescale 1ns/100ps
`default_nettype none
module cpuod_decoder_sva
  import cpuod_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [2:0] kind_req,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic [ADDR_W-1:0] sp,
  input wire logic flag_we,
  input wire logic [7:0] flag_in,
  input wire logic dec_valid,
  input wire logic [7:0] dec_op,
  input wire logic page2,
  input wire logic [2:0] dec_bit,
  input wire logic dec_bit_val,
  input wire logic [2:0] dec_len,
  input wire logic [3:0] dec_cycles,
  input wire logic illegal,
  input wire logic [6:0] cyc_kind,
  input wire logic bus_req,
  input wire logic bus_rw,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0] flag_register
);
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // bus cycle kinds show one enabled edge after the request
  free_no_bus_a: assert property (ce && kind_req == 3'h0 |=>
    cyc_kind == cyc_free && !bus_req && bus_rw)
    else $error("free cycle used the bus");
  fetch_at_pc_a: assert property (ce && kind_req == 3'h1 |=>
    cyc_kind == cyc_fetch && bus_req && bus_rw && bus_addr == $past(pc))
    else $error("fetch cycle wrong");
  operand_read_a: assert property (ce && kind_req == 3'h2 |=>
    cyc_kind == cyc_read && bus_req && bus_rw)
    else $error("operand read wrong");
  operand_write_a: assert property (ce && kind_req == 3'h3 |=>
    cyc_kind == cyc_write && bus_req && !bus_rw)
    else $error("operand write wrong");
  push_to_stack_a: assert property (ce && kind_req == 3'h4 |=>
    cyc_kind == cyc_push && !bus_rw && bus_addr == $past(sp))
    else $error("push cycle wrong");
  pop_from_stack_a: assert property (ce && kind_req == 3'h5 |=>
    cyc_kind == cyc_pop && bus_req && bus_rw)
    else $error("pop cycle wrong");
  vector_page_a: assert property (ce && kind_req == 3'h6 |=>
    cyc_kind == cyc_vect && bus_rw && bus_addr[15:8] == 8'hff)
    else $error("vector read off the top page");
  vector_order_a: assert property (ce && kind_req == 3'h0 ##1
    (ce && kind_req == 3'h6) [*2] |-> !bus_addr[0] ##1 bus_addr[0])
    else $error("vector bytes out of order");
  flag_write_a: assert property (ce && flag_we |=>
    flag_register == ($past(flag_in) | FLAG_FIXED_ONES))
    else $error("flag register write wrong");
  // attribute checks on page-one decode results of the 0x, 1x and 2x columns
  bit_branch_a: assert property (dec_valid && !page2 &&
    dec_op[7:4] == 4'h0 |-> dec_len == 3'h3 && dec_cycles == 4'h5 &&
    dec_bit == dec_op[3:1] && dec_bit_val == !dec_op[0])
    else $error("bit branch decode wrong");
  bit_write_a: assert property (dec_valid && !page2 &&
    dec_op[7:4] == 4'h1 |-> dec_len == 3'h2 && dec_cycles == 4'h5 &&
    dec_bit == dec_op[3:1] && dec_bit_val == !dec_op[0])
    else $error("bit write decode wrong");
  rel_branch_a: assert property (dec_valid && !page2 &&
    dec_op[7:4] == 4'h2 |-> dec_len == 3'h2 && dec_cycles == 4'h3)
    else $error("relative branch decode wrong");
  illegal_alone_a: assert property (illegal |-> !dec_valid)
    else $error("illegal op also decoded");
endmodule
bind cpuod_decoder cpuod_decoder_sva #(.ADDR_W(ADDR_W)) i_sva (.*);
`default_nettype wire

// File: testbench/cpuod_mem_model.sv
// system memory model on the far side of the decoder bus
`timescale 1ns/100ps
`default_nettype none
module cpuod_mem_model
(
  input wire logic clk,
  input wire logic ce,
  input wire logic bus_req,
  input wire logic bus_rw,
  input wire logic [15:0] bus_addr,
  output logic [7:0] rdata,
  output int wr_cnt,
  output int rd_cnt
);
  logic ce_q;
  // one byte per enabled bus cycle; idle data wanders so no stale match
  // outputs are fresh only after an enabled edge, so count on ce_q
  always @(posedge clk)
  begin
    ce_q <= ce;
    rdata <= ~rdata;
    if (ce_q && bus_req && !bus_rw)
      wr_cnt <= wr_cnt + 1;
    if (ce_q && bus_req && bus_rw)
    begin
      rd_cnt <= rd_cnt + 1;
      rdata <= bus_addr[7:0] ^ 8'h5a;
    end
  end
  initial rdata = 8'h00;
endmodule
`default_nettype wire

// File: testbench/cpuod_decoder_tb.sv
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
`default_nettype none
module cpuod_decoder_tb
  import cpuod_pkg::*;
;
  typedef struct packed {
    logic [7:0] op;
    logic p2;
    logic ill;
    logic [2:0] len;
    logic [3:0] cyc;
    logic [13:0] mode;
  } cpuod_exp_s;
  localparam logic [3:0] RM_CYC [0:5] = '{2, 3, 4, 4, 3, 3};
  localparam logic [2:0] RM_LEN [0:5] = '{2, 2, 3, 3, 2, 1};
  localparam logic [13:0] RM_MODE [0:5] = '{literal_operand_mode,
    direct_mode, full_address_mode, pointer_word_offset_mode,
    pointer_byte_offset_mode, pointer_mode};
  localparam logic [3:0] MW_CYC [0:4] = '{5, 1, 1, 5, 4};
  localparam logic [2:0] MW_LEN [0:4] = '{2, 1, 1, 2, 1};
  localparam logic [13:0] MW_MODE [0:4] = '{direct_mode, implied_mode,
    implied_mode, pointer_byte_offset_mode, pointer_mode};
  logic clk, rst_b, ce, op_valid, flag_we, ce_seen, pre;
  logic [7:0] op, vec_low, flag_in, dec_op, dec_class, flag_register, rnd;
  logic [2:0] kind_req, dec_len;
  logic [15:0] pc, sp, bus_addr;
  logic [3:0] dec_alu_op, dec_cycles;
  logic [13:0] dec_mode;
  logic dec_valid, page2, illegal, bus_req, bus_rw;
  int error_cnt, checks, seed, n_wr, n_rd, wr_cnt, rd_cnt, i;
  cpuod_exp_s exp_q[$];
  cpuod_exp_s e;
  logic [7:0] dir_ops[] = '{8'h00, 8'h01, 8'h0e, 8'h1f, 8'h10, 8'h20,
    8'h2f, 8'h30, 8'h44, 8'h5f, 8'h61, 8'h71, 8'h66, 8'h7a, 8'h45, 8'h55,
    8'h65, 8'h75, 8'h96, 8'h8d, 8'hac, 8'ha6, 8'hb7, 8'hc6, 8'hdc, 8'he0,
    8'hf6, 8'hf7, 8'hff, 8'h9e, 8'hd6, 8'h9e, 8'he6, 8'hbf, 8'h8d};
  cpuod_decoder i_cpuod_decoder (.clk, .rst_b, .ce, .op_valid, .op,
    .kind_req, .pc, .sp, .vec_low, .flag_we, .flag_in, .dec_valid,
    .dec_op, .page2, .dec_class, .dec_mode, .dec_alu_op, .dec_bit(),
    .dec_bit_val(), .dec_len, .dec_cycles, .illegal, .cyc_kind(),
    .bus_req, .bus_rw, .bus_addr, .flag_register);
  cpuod_mem_model i_cpuod_mem_model (.clk, .ce, .bus_req, .bus_rw,
    .bus_addr, .rdata(), .wr_cnt, .rd_cnt);
  always #20 clk = ~clk;
  // expected decode attributes; zero len, cyc and mode fields are left unchecked
  function automatic cpuod_exp_s ref_dec(input logic [7:0] o,
    input logic p);
    cpuod_exp_s r;
    logic [3:0] h;
    h = o[7:4];
    r = '{o, p, 1'b0, 3'h0, 4'h0, 14'h0};
    if (p)
      r.mode = h[0] ? stack_word_offset_mode : stack_byte_offset_mode;
    else if (o == 8'h8d || o == 8'hac)
      r.ill = 1'b1;
    else if (h < 4'h3)
      r = '{o, p, 1'b0, (h == 0) ? 3'h3 : 3'h2, h[1] ? 4'h3 : 4'h5, 14'h0};
    else if (o[3:0] == 4'h5 && h[3:2] == 2'b01)
      r = '{o, p, 1'b0, h[0] ? 3'h2 : 3'h3,
        (h == 4'h5) ? 4'h4 : (h == 4'h7) ? 4'h5 : 4'h3,
        h[0] ? direct_mode : literal_operand_mode};
    else if (o == OP_PTR_ST_EXT)
      r = '{o, p, 1'b0, 3'h3, 4'h5, full_address_mode};
    else if (o[3:0] == 4'h1 && h[3:1] == 3'b011)
      r.mode = h[0] ? pointer_postinc_mode : pointer_offset_postinc_mode;
    else if (h < 4'h8 && !(o[3:0] inside {1, 2, 5, 11, 13, 14}))
      r = '{o, p, 1'b0, MW_LEN[h-3], MW_CYC[h-3], MW_MODE[h-3]};
    else if (h >= 4'ha && o[3:0] != 4'hd && o != 8'ha7 && o != 8'haf)
      r = '{o, p, 1'b0, RM_LEN[h-10], (o == OP_STORE_A_NOOFF ||
        o == OP_STORE_X_NOOFF) ? 4'h2 : RM_CYC[h-10], RM_MODE[h-10]};
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // one opcode byte per clock; the prebyte only marks the next byte
  task automatic send(input logic [7:0] o);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    if (o == OP_PREBYTE && !pre)
      pre = 1'b1;
    else
    begin
      exp_q.push_back(ref_dec(o, pre));
      pre = 1'b0;
    end
  endtask
  // one bus request, counted as the partner should see it
  task automatic bus(input logic [2:0] k, input logic c);
    @(posedge clk);
    kind_req <= k;
    ce <= c;
    pc <= $random(seed);
    sp <= $random(seed);
    vec_low <= $random(seed);
    flag_we <= $random(seed);
    flag_in <= $random(seed);
    n_wr += (c && k inside {3, 4});
    n_rd += (c && k inside {1, 2, 5, 6});
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // outputs stand while ce is low, so only fresh results are taken
  always @(posedge clk) ce_seen <= ce;
  always @(negedge clk)
  begin
    if (rst_b && ce_seen && (dec_valid || illegal))
    begin
      if (exp_q.size() == 0)
        chk(dec_op, 16'hffff);
      else
      begin
        e = exp_q.pop_front();
        chk(illegal, e.ill);
        if (e.ill) chk(dec_class, cls_illegal);
        if (!e.ill) chk(page2, e.p2);
        if (!e.ill) chk(dec_op, e.op);
        if (!e.p2 && (e.op == OP_PTR_ST_EXT || e.op == OP_PTR_LD_IMM))
          chk(dec_class, cls_pointer);
        if (e.len != 0) chk(dec_len, e.len);
        if (e.cyc != 0) chk(dec_cycles, e.cyc);
        if (e.mode != 0) chk(dec_mode, e.mode);
        if (e.mode != 0 && !e.p2 && e.op >= 8'ha0)
          chk(dec_alu_op, e.op[3:0]);
        if (e.mode != 0 && !e.p2 && e.op >= 8'ha0)
          chk(dec_class, cls_regmem);
      end
    end
  end
  initial
  begin
    {clk, rst_b, op_valid, flag_we, pre, op, vec_low, flag_in} = '0;
    {kind_req, pc, sp, n_wr, n_rd} = '0;
    ce = 1'b1;
    seed = 92911;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(flag_register, FLAG_RESET);
    foreach (dir_ops[i]) send(dir_ops[i]);
    @(posedge clk);
    // drop valid on the same edge as ce, or the held byte is taken again after the stall
    op_valid <= 1'b0;
    ce <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      rnd = $random(seed);
      send((rnd | 8'h80) == OP_PREBYTE ? 8'h9d : rnd | 8'h80);
    end
    @(posedge clk);
    op_valid <= 1'b0;
    for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0)
    begin
      error_cnt++;
      complete_run();
    end
    @(posedge clk);
    flag_we <= 1'b1;
    flag_in <= 8'h00;
    @(posedge clk);
    flag_we <= 1'b0;
    @(negedge clk);
    chk(flag_register, FLAG_FIXED_ONES);
    n_wr = wr_cnt;
    n_rd = rd_cnt;
    bus(3'h0, 1'b1);
    bus(3'h6, 1'b1);
    bus(3'h6, 1'b1);
    for (i = 0; i < 300; i++)
      bus($unsigned($random(seed)) % 7, ($random(seed) & 3) != 0);
    repeat (3) bus(3'h0, 1'b1);
    chk(wr_cnt, n_wr);
    chk(rd_cnt, n_rd);
    complete_run();
  end
endmodule
`default_nettype wire
